// ### rtl/rtc_alarm_cfg.sv
// alarm configuration, repeat counter and calendar year register
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - codes 0100..1000 give ten minutes to yearly; Feb 29 every four years; 1001+ never fire
// R2 - code 0000 fires each half second, 0001 each second, 0011 each minute
// R3 - alarm window pointer selects the word behind the high and low ports
// R4 - each high-port access steps the pointer down, stopping at zero
// R5 - pointer 10 shows month and day, 01 weekday and hours
// R6 - repeat count holds the number of further alarm repeats
// R7 - repeat count drops on each alarm, holds at zero without chime
// R8 - with chime the repeat count wraps from 00 to FF
// R9 - time pointer 11 puts the year on the time value port
// R10 - year bits 7:4 hold the BCD tens digit, 0 to 9
// R11 - year bits 3:0 hold the BCD ones digit, 0 to 9
// R12 - year bits 15:8 read zero and ignore writes
// R13 - year write taken only while the time write unlock is set
////////////////////////////////////////////////////////////////////////////////
module rtc_alarm_cfg #(
    parameter int HALF_SEC_CYC = rtc_alarm_pkg::HALF_SEC_CYC_DEF
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [rtc_alarm_pkg::ADDR_W-1:0] addr_i,
    input wire logic [rtc_alarm_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic alarm_enable_i,
    output logic [rtc_alarm_pkg::DATA_W-1:0] rdata_o,
    output logic irq_o,
    output logic alarm_pulse_o
);
    import rtc_alarm_pkg::*;

    localparam int DIV_W = $clog2(HALF_SEC_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // out-of-range digits saturate so the year never holds a non-BCD code
    function automatic logic [3:0] bcd_clamp(input logic [3:0] d);
        return (d > BCD_MAX) ? BCD_MAX : d;
    endfunction

    function automatic logic [PER_W-1:0] period_of(input logic [3:0] code,
                                                   input logic leap);
        logic [PER_W-1:0] p;
        p = PER_NONE;
        case (code)
            IVL_HALF: p = PER_HALF; // [R2]
            IVL_SEC: p = PER_SEC; // [R2]
            IVL_10S: p = PER_10S;
            IVL_MIN: p = PER_MIN; // [R2]
            IVL_10MIN: p = PER_10MIN; // [R1]
            IVL_HOUR: p = PER_HOUR; // [R1]
            IVL_DAY: p = PER_DAY; // [R1]
            IVL_WEEK: p = PER_WEEK; // [R1]
            IVL_YEAR: p = leap ? PER_4YEAR : PER_YEAR; // [R1]
            default: p = PER_NONE; // [R1]
        endcase
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register state

    alarm_mem_if mif ();

    logic [3:0] mask_r;
    logic [1:0] ptr_r;
    logic chime_r;
    logic [7:0] rpt_r;
    logic unlock_r;
    logic [1:0] tptr_r;
    logic [7:0] year_r;
    logic [STAT_W-1:0] stat_r;
    logic [STAT_W-1:0] stat_nxt;
    logic [STAT_W-1:0] imask_r;
    logic [STAT_W-1:0] imask_nxt;
    logic irq_r;
    logic pulse_r;

    logic wr_cfg;
    logic wr_tctl;
    logic wr_year;
    logic wr_imask;
    logic rd_stat;
    logic alm_port;
    logic hi_acc;
    logic [15:0] rd_mux;

    assign wr_cfg = wr_i && addr_i == OFF_ALM_CFG;
    assign wr_tctl = wr_i && addr_i == OFF_TIME_CTL;
    assign wr_imask = wr_i && addr_i == OFF_INT_MASK;
    assign rd_stat = rd_i && addr_i == OFF_INT_STAT;
    assign alm_port = addr_i == OFF_ALM_LO || addr_i == OFF_ALM_HI;
    assign hi_acc = (wr_i || rd_i) && addr_i == OFF_ALM_HI;
    assign wr_year = wr_i && addr_i == OFF_TIME_VAL && tptr_r == YEAR_PTR
                     && unlock_r; // [R9] [R13]

    ////////////////////////////////////////////////////////////////////////////
    // half-second enable

    logic [DIV_W-1:0] div_r;
    logic half_tick_r;

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            div_r <= '0;
            half_tick_r <= 1'b0;
        end else if (div_r == DIV_W'(HALF_SEC_CYC - 1)) begin
            div_r <= '0;
            half_tick_r <= 1'b1;
        end else begin
            div_r <= div_r + 1'b1;
            half_tick_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm interval timing

    logic [PER_W-1:0] ivl_r;
    logic [PER_W-1:0] period;
    logic leap;
    logic fire;

    assign leap = mif.mon_day[12:8] == FEB_MONTH && mif.mon_day[5:0] == LEAP_DAY; // [R1]
    assign period = period_of(mask_r, leap);
    // reserved codes give a zero period and never fire
    assign fire = alarm_enable_i && half_tick_r && period != PER_NONE
                  && ivl_r >= period - 1'b1; // [R1] [R2]

    // restarting on a config write keeps a new code from firing early
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || !alarm_enable_i || wr_cfg) begin
            ivl_r <= '0;
        end else if (half_tick_r) begin
            ivl_r <= fire ? '0 : ivl_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= fire;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // alarm configuration register

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            mask_r <= MASK_RST;
            chime_r <= 1'b0;
        end else if (wr_cfg) begin
            mask_r <= wdata_i[CFG_MASK_LSB +: 4]; // [R1]
            chime_r <= wdata_i[CFG_CHIME_BIT]; // [R8]
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            ptr_r <= PTR_RST;
        end else if (wr_cfg) begin
            ptr_r <= wdata_i[CFG_PTR_LSB +: 2]; // [R3]
        end else if (hi_acc && ptr_r != PTR_MIN_SEC) begin
            ptr_r <= ptr_r - 2'h1; // [R4]
        end
    end

    // a software write in the same cycle as an alarm wins
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rpt_r <= RPT_RST;
        end else if (wr_cfg) begin
            rpt_r <= wdata_i[7:0]; // [R6]
        end else if (fire) begin
            if (rpt_r != RPT_RST) begin
                rpt_r <= rpt_r - 8'h01; // [R7]
            end else if (chime_r) begin
                rpt_r <= RPT_WRAP; // [R8]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // time window control and year

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            unlock_r <= 1'b0;
            tptr_r <= PTR_RST;
        end else if (wr_tctl) begin
            unlock_r <= wdata_i[TCTL_UNLOCK_BIT];
            tptr_r <= wdata_i[TCTL_PTR_LSB +: 2];
        end
    end

    // only the low byte is stored; upper bits of the write fall away
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            year_r <= YEAR_RST;
        end else if (wr_year) begin // [R13]
            year_r[7:4] <= bcd_clamp(wdata_i[7:4]); // [R10]
            year_r[3:0] <= bcd_clamp(wdata_i[3:0]); // [R11] [R12]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask

    always_comb begin
        stat_nxt = rd_stat ? '0 : stat_r;
        stat_nxt[STAT_EVT_BIT] = stat_nxt[STAT_EVT_BIT] | fire;
        stat_nxt[STAT_DONE_BIT] = stat_nxt[STAT_DONE_BIT]
                                  | (fire && rpt_r == RPT_RST && !chime_r);
        imask_nxt = wr_imask ? wdata_i[STAT_W-1:0] : imask_r;
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            stat_r <= '0;
            imask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            imask_r <= imask_nxt;
            irq_r <= |(stat_nxt & imask_nxt);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        rd_mux = '0;
        case (addr_i)
            OFF_ALM_CFG: begin
                rd_mux[CFG_EN_BIT] = alarm_enable_i;
                rd_mux[CFG_CHIME_BIT] = chime_r;
                rd_mux[CFG_MASK_LSB +: 4] = mask_r;
                rd_mux[CFG_PTR_LSB +: 2] = ptr_r;
                rd_mux[7:0] = rpt_r; // [R6]
            end
            OFF_TIME_CTL: begin
                rd_mux[TCTL_UNLOCK_BIT] = unlock_r;
                rd_mux[TCTL_PTR_LSB +: 2] = tptr_r;
            end
            OFF_TIME_VAL: begin
                if (tptr_r == YEAR_PTR) begin
                    rd_mux = {8'h00, year_r}; // [R9] [R12]
                end
            end
            OFF_INT_STAT: rd_mux[STAT_W-1:0] = stat_r;
            OFF_INT_MASK: rd_mux[STAT_W-1:0] = imask_r;
            default: rd_mux = '0;
        endcase
    end

    assign mif.addr = ptr_r; // [R3]
    assign mif.be = (addr_i == OFF_ALM_HI) ? 2'b10 : 2'b01;
    assign mif.wr = wr_i && alm_port;
    assign mif.rd = rd_i;
    assign mif.wdata = {wdata_i[7:0], wdata_i[7:0]};
    assign mif.byp = !alm_port;
    assign mif.byp_data = rd_mux;

    alarm_value_mem #(
        .WORDS(ALM_WORDS)
    ) u_mem (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .mif(mif)
    );

    assign rdata_o = mif.rdata;
    assign irq_o = irq_r;
    assign alarm_pulse_o = pulse_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    property p_ptr_dec;
        @(posedge clk_sys_i) disable iff (reset_i)
        (hi_acc && ptr_r != PTR_MIN_SEC) |=> ptr_r == $past(ptr_r) - 2'h1;
    endproperty
    a_ptr_dec: assert property (p_ptr_dec) // [R4]
        else $error("pointer did not step down on high port access");

    property p_ptr_floor;
        @(posedge clk_sys_i) disable iff (reset_i)
        (hi_acc && ptr_r == PTR_MIN_SEC) |=> ptr_r == PTR_MIN_SEC;
    endproperty
    a_ptr_floor: assert property (p_ptr_floor) // [R4]
        else $error("pointer wrapped below zero");

    property p_win_read;
        @(posedge clk_sys_i) disable iff (reset_i)
        (rd_i && addr_i == OFF_ALM_LO && ptr_r == PTR_MON_DAY)
        |=> rdata_o == {8'h00, mif.mon_day[7:0]};
    endproperty
    a_win_read: assert property (p_win_read) // [R3]
        else $error("low port did not show the month and day word");

    property p_rpt_dec;
        @(posedge clk_sys_i) disable iff (reset_i)
        (fire && !wr_cfg && rpt_r != RPT_RST) |=> rpt_r == $past(rpt_r) - 8'h01;
    endproperty
    a_rpt_dec: assert property (p_rpt_dec) // [R7]
        else $error("repeat count did not drop on alarm");

    property p_rpt_hold;
        @(posedge clk_sys_i) disable iff (reset_i)
        (fire && !wr_cfg && rpt_r == RPT_RST && !chime_r) |=> rpt_r == RPT_RST;
    endproperty
    a_rpt_hold: assert property (p_rpt_hold) // [R7]
        else $error("repeat count rolled over without chime");

    property p_rpt_wrap;
        @(posedge clk_sys_i) disable iff (reset_i)
        (fire && !wr_cfg && rpt_r == RPT_RST && chime_r) |=> rpt_r == RPT_WRAP;
    endproperty
    a_rpt_wrap: assert property (p_rpt_wrap) // [R8]
        else $error("repeat count did not wrap with chime");

    property p_reserved;
        @(posedge clk_sys_i) disable iff (reset_i)
        mask_r > IVL_YEAR |-> !fire;
    endproperty
    a_reserved: assert property (p_reserved) // [R1]
        else $error("reserved interval code fired");

    property p_half_sec;
        @(posedge clk_sys_i) disable iff (reset_i)
        (half_tick_r && alarm_enable_i && mask_r == IVL_HALF) |=> alarm_pulse_o;
    endproperty
    a_half_sec: assert property (p_half_sec) // [R2]
        else $error("alarm pulse did not follow the alarm");

    property p_year_lock;
        @(posedge clk_sys_i) disable iff (reset_i)
        (wr_i && addr_i == OFF_TIME_VAL && !unlock_r) |=> $stable(year_r);
    endproperty
    a_year_lock: assert property (p_year_lock) // [R13]
        else $error("year changed while locked");

    property p_year_bcd;
        @(posedge clk_sys_i) disable iff (reset_i)
        year_r[7:4] <= BCD_MAX && year_r[3:0] <= BCD_MAX;
    endproperty
    a_year_bcd: assert property (p_year_bcd) // [R10] [R11]
        else $error("year digit outside 0 to 9");

    property p_year_read;
        @(posedge clk_sys_i) disable iff (reset_i)
        (rd_i && addr_i == OFF_TIME_VAL && tptr_r == YEAR_PTR)
        |=> rdata_o == {8'h00, $past(year_r)};
    endproperty
    a_year_read: assert property (p_year_read) // [R9] [R12]
        else $error("year read did not return the year with a zero top byte");

    property p_irq;
        @(posedge clk_sys_i) disable iff (reset_i)
        ##1 irq_o == |(stat_r & imask_r);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output disagrees with status and mask");
endmodule
`default_nettype wire

// ### rtl/rtc_alarm_pkg.sv
// shared constants for the alarm configuration and year block
`default_nettype none
package rtc_alarm_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    // register offsets (word index on the register port)
    localparam logic [2:0] OFF_ALM_CFG = 3'h0;
    localparam logic [2:0] OFF_ALM_LO = 3'h1;
    localparam logic [2:0] OFF_ALM_HI = 3'h2;
    localparam logic [2:0] OFF_TIME_CTL = 3'h3;
    localparam logic [2:0] OFF_TIME_VAL = 3'h4;
    localparam logic [2:0] OFF_INT_STAT = 3'h5;
    localparam logic [2:0] OFF_INT_MASK = 3'h6;
    // field positions
    localparam int CFG_EN_BIT = 15;
    localparam int CFG_CHIME_BIT = 14;
    localparam int CFG_MASK_LSB = 10;
    localparam int CFG_PTR_LSB = 8;
    localparam int TCTL_UNLOCK_BIT = 0;
    localparam int TCTL_PTR_LSB = 8;
    localparam int STAT_EVT_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_W = 2;
    // window pointer values
    localparam logic [1:0] PTR_MIN_SEC = 2'h0;
    localparam logic [1:0] PTR_WDAY_HR = 2'h1;
    localparam logic [1:0] PTR_MON_DAY = 2'h2;
    localparam logic [1:0] YEAR_PTR = 2'h3;
    localparam int ALM_WORDS = 3;
    // values after reset, repeat wrap value and calendar limits
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [1:0] PTR_RST = 2'h0;
    localparam logic [7:0] RPT_RST = 8'h00;
    localparam logic [7:0] YEAR_RST = 8'h00;
    localparam logic [7:0] RPT_WRAP = 8'hff;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [4:0] FEB_MONTH = 5'h02;
    localparam logic [5:0] LEAP_DAY = 6'h29;
    // interval codes
    localparam logic [3:0] IVL_HALF = 4'h0;
    localparam logic [3:0] IVL_SEC = 4'h1;
    localparam logic [3:0] IVL_10S = 4'h2;
    localparam logic [3:0] IVL_MIN = 4'h3;
    localparam logic [3:0] IVL_10MIN = 4'h4;
    localparam logic [3:0] IVL_HOUR = 4'h5;
    localparam logic [3:0] IVL_DAY = 4'h6;
    localparam logic [3:0] IVL_WEEK = 4'h7;
    localparam logic [3:0] IVL_YEAR = 4'h8;
    // periods in half-second ticks
    localparam int PER_W = 28;
    localparam logic [27:0] PER_HALF = 28'h000_0001;
    localparam logic [27:0] PER_SEC = 28'h000_0002;
    localparam logic [27:0] PER_10S = 28'h000_0014;
    localparam logic [27:0] PER_MIN = 28'h000_0078;
    localparam logic [27:0] PER_10MIN = 28'h000_04b0;
    localparam logic [27:0] PER_HOUR = 28'h000_1c20;
    localparam logic [27:0] PER_DAY = 28'h002_a300;
    localparam logic [27:0] PER_WEEK = 28'h012_7500;
    localparam logic [27:0] PER_YEAR = 28'h3c2_6700;
    localparam logic [27:0] PER_4YEAR = 28'hf0c_3f00;
    localparam logic [27:0] PER_NONE = 28'h000_0000;
    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int HALF_SEC_NS = 500000000;
    localparam int HALF_SEC_CYC_DEF = HALF_SEC_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ### rtl/alarm_mem_if.sv
// link between the register logic and the alarm value store
`timescale 1ns/1ps
`default_nettype none
interface alarm_mem_if;
    logic [1:0] addr;
    logic [1:0] be;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic byp;
    logic [15:0] byp_data;
    logic [15:0] rdata;
    logic [15:0] mon_day;
    modport ctl (output addr, be, wr, rd, wdata, byp, byp_data, input rdata, mon_day);
    modport mem (input addr, be, wr, rd, wdata, byp, byp_data, output rdata, mon_day);
endinterface
`default_nettype wire

// ### rtl/alarm_value_mem.sv
// alarm value words and the registered read-data path of the register port
`timescale 1ns/1ps
`default_nettype none
module alarm_value_mem #(
    parameter int WORDS = rtc_alarm_pkg::ALM_WORDS
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    alarm_mem_if.mem mif
);
    import rtc_alarm_pkg::*;

    logic [15:0] word_r [WORDS];
    logic [15:0] sel_word;
    logic hit;

    // pointer 11 has no word behind it: reads zero, writes dropped
    assign hit = 32'(mif.addr) < WORDS; // [R3]
    assign sel_word = hit ? word_r[mif.addr] : '0; // [R5]

    genvar g;
    generate
        for (g = 0; g < WORDS; g++) begin : g_word
            always_ff @(posedge clk_sys_i) begin
                if (reset_i) begin
                    word_r[g] <= '0;
                end else if (mif.wr && hit && mif.addr == 2'(g)) begin // [R3]
                    if (mif.be[0]) begin
                        word_r[g][7:0] <= mif.wdata[7:0];
                    end
                    if (mif.be[1]) begin
                        word_r[g][15:8] <= mif.wdata[15:8];
                    end
                end
            end
        end
    endgenerate

    // data stand only in the cycle after the read strobe
    always_ff @(posedge clk_sys_i) begin
        if (reset_i || !mif.rd) begin
            mif.rdata <= '0;
        end else if (mif.byp) begin
            mif.rdata <= mif.byp_data;
        end else if (mif.be[1]) begin
            mif.rdata <= {8'h00, sel_word[15:8]};
        end else begin
            mif.rdata <= {8'h00, sel_word[7:0]};
        end
    end

    assign mif.mon_day = word_r[PTR_MON_DAY];
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the alarm configuration and year block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rtc_alarm_pkg::*;
    typedef struct {
        logic [2:0] a;
        logic [15:0] d;
        logic [15:0] e;
    } row_s;
    localparam int HSC = 4;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [2:0] addr_i = 3'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic alarm_enable_i = 1'b0;
    logic [15:0] rdata_o;
    logic irq_o;
    logic alarm_pulse_o;
    int errors = 0;
    int n_tests = 0;
    int per [6] = '{1, 2, 20, 120, 1200, 7200};
    row_s rows [6];
    logic [15:0] rv;
    int c;

    rtc_alarm_cfg #(.HALF_SEC_CYC(HSC)) rtc_alarm_cfg_i (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .alarm_enable_i(alarm_enable_i),
        .rdata_o(rdata_o),
        .irq_o(irq_o),
        .alarm_pulse_o(alarm_pulse_o)
    );

    always #12.5 clk_sys_i = ~clk_sys_i;

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one-cycle gap after each strobe so no signal is assigned twice per step
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        @(posedge clk_sys_i);
        // sampled at the edge that ends the one cycle the data stand
        d = rdata_o;
    endtask

    task automatic wait_pulse(input int bound, output int n);
        n = 0;
        while (n < bound) begin
            @(posedge clk_sys_i);
            n++;
            if (alarm_pulse_o === 1'b1) begin
                break;
            end
        end
        if (alarm_pulse_o !== 1'b1) begin
            errors++;
            $display("ERROR %0t alarm pulse missing", $time);
        end
    endtask

    task automatic alarm_once();
        int n;
        alarm_enable_i <= 1'b1;
        wait_pulse(4 * HSC + 8, n);
        alarm_enable_i <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rows = '{'{3'h3, 16'h0301, 16'h0301}, '{3'h4, 16'hff59, 16'h0059},
                 '{3'h4, 16'h00ab, 16'h0099}, '{3'h7, 16'hffff, 16'h0000},
                 '{3'h6, 16'h0003, 16'h0003}, '{3'h0, 16'h5205, 16'h5205}};
        repeat (6) @(posedge clk_sys_i);
        chk({rdata_o[15:2], irq_o, alarm_pulse_o}, 16'h0000);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        for (int i = 0; i < 6; i++) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a, rv);
            chk(rv, rows[i].e);
        end
        // year lock: write with unlock clear must be dropped
        wr_reg(3'h3, 16'h0300);
        wr_reg(3'h4, 16'h0012);
        wr_reg(3'h3, 16'h0301);
        rd_reg(3'h4, rv);
        chk(rv, 16'h0099);
        wr_reg(3'h3, 16'h0201);
        rd_reg(3'h4, rv);
        chk(rv, 16'h0000);
        // alarm words through the window, pointer walking down to zero
        wr_reg(3'h0, 16'h0200);
        wr_reg(3'h1, 16'h0029);
        wr_reg(3'h2, 16'h0002);
        wr_reg(3'h1, 16'h0013);
        wr_reg(3'h2, 16'h0005);
        wr_reg(3'h1, 16'h0045);
        wr_reg(3'h2, 16'h0030);
        rd_reg(3'h0, rv);
        chk(rv, 16'h0000);
        wr_reg(3'h0, 16'h0200);
        rd_reg(3'h1, rv);
        chk(rv, 16'h0029);
        rd_reg(3'h2, rv);
        chk(rv, 16'h0002);
        rd_reg(3'h1, rv);
        chk(rv, 16'h0013);
        rd_reg(3'h2, rv);
        chk(rv, 16'h0005);
        rd_reg(3'h2, rv);
        chk(rv, 16'h0030);
        rd_reg(3'h2, rv);
        chk(rv, 16'h0030);
        rd_reg(3'h0, rv);
        chk(rv, 16'h0000);
        // repeat counter, sticky status, mask and interrupt
        wr_reg(3'h6, 16'h0001);
        wr_reg(3'h0, 16'h0001);
        rd_reg(3'h5, rv);
        alarm_once();
        chk(16'(irq_o), 16'h0001);
        rd_reg(3'h0, rv);
        chk(rv, 16'h0000);
        alarm_once();
        rd_reg(3'h0, rv);
        chk(rv, 16'h0000);
        rd_reg(3'h5, rv);
        chk(rv, 16'h0003);
        repeat (2) @(posedge clk_sys_i);
        chk(16'(irq_o), 16'h0000);
        rd_reg(3'h5, rv);
        chk(rv, 16'h0000);
        wr_reg(3'h6, 16'h0000);
        alarm_once();
        chk(16'(irq_o), 16'h0000);
        rd_reg(3'h5, rv);
        chk(rv, 16'h0003);
        wr_reg(3'h0, 16'h4000);
        alarm_once();
        rd_reg(3'h0, rv);
        chk(rv, 16'h40ff);
        alarm_once();
        rd_reg(3'h0, rv);
        chk(rv, 16'h40fe);
        // spacing between consecutive alarms for each short interval code
        for (int k = 0; k < 6; k++) begin
            wr_reg(3'h0, 16'h4000 | 16'(k << 10));
            alarm_enable_i <= 1'b1;
            wait_pulse(per[k] * HSC + 12, c);
            wait_pulse(per[k] * HSC + 12, c);
            chk(16'(c), 16'(per[k] * HSC));
            alarm_enable_i <= 1'b0;
        end
        // reserved codes 1001 and 1111 never fire
        for (int k = 9; k < 16; k += 6) begin
            wr_reg(3'h0, 16'(k << 10));
            alarm_enable_i <= 1'b1;
            c = 0;
            repeat (100) begin
                @(posedge clk_sys_i);
                if (alarm_pulse_o === 1'b1) begin
                    c++;
                end
            end
            chk(16'(c), 16'h0000);
            alarm_enable_i <= 1'b0;
        end
        // reset again in mid-run: everything back to zero
        wr_reg(3'h6, 16'h0001);
        chk(16'(irq_o), 16'h0001);
        reset_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        chk(16'(irq_o), 16'h0000);
        rd_reg(3'h5, rv);
        chk(rv, 16'h0000);
        rd_reg(3'h0, rv);
        chk(rv, 16'h0000);
        rd_reg(3'h3, rv);
        chk(rv, 16'h0000);
        rd_reg(3'h6, rv);
        chk(rv, 16'h0000);
        complete_run();
    end

    // longest interval code dominates; this limit sits well above the whole run
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        errors++;
        $display("ERROR %0t watchdog expired", $time);
        complete_run();
    end
endmodule
`default_nettype wire
